//--- rtl/dcsrx_pkg.sv
package dcsrx_pkg;

  // Select pin encodings: {dll_ratio_select, dll_enable_select}.
  localparam logic [1:0] SEL_BYPASS = 2'h0;
  localparam logic [1:0] SEL_MUL4   = 2'h1;
  localparam logic [1:0] SEL_MUL3   = 2'h2;
  localparam logic [1:0] SEL_MUL6   = 2'h3;

  localparam logic [2:0] MULT_NONE = 3'h1;
  localparam logic [2:0] MULT_X3   = 3'h3;
  localparam logic [2:0] MULT_X4   = 3'h4;
  localparam logic [2:0] MULT_X6   = 3'h6;

  // Sampling rate codes for the judgment time.
  localparam logic [1:0] FS_32K  = 2'h0;
  localparam logic [1:0] FS_44K1 = 2'h1;
  localparam logic [1:0] FS_48K  = 2'h2;
  localparam logic [1:0] FS_96K  = 2'h3;

  // Judgment times in milliseconds.
  localparam logic [10:0] JUDGE_MS_32K  = 11'h3e8;
  localparam logic [10:0] JUDGE_MS_44K1 = 11'h2ee;
  localparam logic [10:0] JUDGE_MS_48K  = 11'h2bc;
  localparam logic [10:0] JUDGE_MS_96K  = 11'h15e;

  // Clock rate and the millisecond prescale derived from it.
  localparam int REF_CLK_KHZ = 20000;
  localparam int MS_TIME     = 1;
  localparam int MS_CYCLES   = REF_CLK_KHZ * MS_TIME;

  // Free-running VCO frequency in kHz (80 MHz).
  localparam logic [16:0] FREE_RUN_KHZ = 17'h13880;

  // Cycles after reset release before the select pins are captured.
  localparam logic [2:0] CFG_SETTLE = 3'h5;

  // Default window of VCO edges per receive edge interval.
  localparam int VCO_MIN_DEF = 2;
  localparam int VCO_MAX_DEF = 12;

  typedef struct packed {
    logic       bypass;
    logic [2:0] mult;
  } dcsrx_cfg_type;

  typedef enum logic [1:0] {
    DCSRX_WAIT  = 2'h0,
    DCSRX_ACTV  = 2'h1,
    DCSRX_FREE  = 2'h3
  } dcsrx_mon_type;

endpackage : dcsrx_pkg

//--- rtl/dcsrx_sync.sv
`timescale 1ns/1ps
module dcsrx_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Asynchronous input and filtered output
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_sync_out;

  // A bit only changes once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_sync_out[i] = (s2[i] == s3[i]) ? s3[i] : sync_out[i];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      sync_out <= '0;
    end else begin
      s1       <= async_in;
      s2       <= s1;
      s3       <= s2;
      sync_out <= next_sync_out;
    end
  end

endmodule : dcsrx_sync

//--- rtl/dcsrx_top.sv
`timescale 1ns/1ps
// What this block does
// - Two select pins pick external clock bypass or crystal times 4, 3, 6.
// - Core clock runs at half the selected DLL clock, up to 75 MIPS.
// - A receive input that goes silent past the fs judgment time after its first edge frees the VCO.
// - While free-running, VCO and recovered clock sit at about 80 MHz.
// - On input loss, a clock switch is requested from program or host.
// - Receive edges versus VCO rate find false lock; escape pin is driven.
// - Lock pin high while locked; when unlocked, received data is held.
module dcsrx_top #(
  parameter int MS_COUNT = dcsrx_pkg::MS_CYCLES,
  parameter int VCO_MIN  = dcsrx_pkg::VCO_MIN_DEF,
  parameter int VCO_MAX  = dcsrx_pkg::VCO_MAX_DEF
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // Clock select pins
  input  wire logic                 dll_ratio_select,
  input  wire logic                 dll_enable_select,
  // DLL clock tick from the oscillator, same domain
  input  wire logic                 dll_clock_tick,
  // Receiver pins
  input  wire logic                 rx_in,
  input  wire logic                 vco_clock_in,
  input  wire logic                 pll_lock_in,
  input  wire logic [1:0]           fs_select,
  // Clock control results
  output dcsrx_pkg::dcsrx_cfg_type  clock_cfg,
  output logic                      core_clock_tick,
  // Receiver monitor results
  output logic                      vco_free_run,
  output logic [16:0]               recovered_clock_khz,
  output logic                      clock_switch_request,
  output logic                      false_lock_escape_out,
  output logic                      false_lock_escape_oe,
  output logic                      lock_out,
  output logic                      hold_received
);
  import dcsrx_pkg::*;
  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  if (MS_COUNT < 2 || VCO_MIN < 1 ||
      VCO_MAX <= VCO_MIN || VCO_MAX > 255) begin : g_bad_param
    $error("dcsrx_top: unsupported parameter values");
  end

  logic [1:0] sel_sync;
  logic [2:0] rx_sync;

  dcsrx_sync #(.WIDTH(2)) u_sel_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in ({dll_ratio_select, dll_enable_select}),
    .sync_out (sel_sync)
  );

  dcsrx_sync #(.WIDTH(3)) u_rx_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in ({rx_in, vco_clock_in, pll_lock_in}),
    .sync_out (rx_sync)
  );

  wire logic rx_level  = rx_sync[2];
  wire logic vco_level = rx_sync[1];
  wire logic pll_lock  = rx_sync[0];

  // The pins are captured once after reset; later changes are ignored,
  // so a glitching strap cannot switch the core clock mid-run.
  logic [2:0]    settle;
  logic          cfg_done;
  dcsrx_cfg_type next_cfg;
  logic [2:0]    next_settle;
  logic          next_cfg_done;

  always_comb begin
    next_cfg      = clock_cfg;
    next_settle   = settle;
    next_cfg_done = cfg_done;
    if (!cfg_done) begin
      if (settle == CFG_SETTLE) begin
        next_cfg_done = 1'b1;
        case (sel_sync)
          SEL_BYPASS: next_cfg = '{bypass: 1'b1, mult: MULT_NONE};
          SEL_MUL4:   next_cfg = '{bypass: 1'b0, mult: MULT_X4};
          SEL_MUL3:   next_cfg = '{bypass: 1'b0, mult: MULT_X3};
          SEL_MUL6:   next_cfg = '{bypass: 1'b0, mult: MULT_X6};
          default:    next_cfg = '{bypass: 1'b1, mult: MULT_NONE};
        endcase
      end else begin
        next_settle = settle + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_cfg <= '{bypass: 1'b1, mult: MULT_NONE};
      settle    <= 3'h0;
      cfg_done  <= 1'b0;
    end else begin
      clock_cfg <= next_cfg;
      settle    <= next_settle;
      cfg_done  <= next_cfg_done;
    end
  end

  // Core clock: every second DLL tick, only once the source is fixed.
  logic phase;
  logic next_phase;
  logic next_core_tick;

  always_comb begin
    next_phase     = phase;
    next_core_tick = 1'b0;
    if (cfg_done && dll_clock_tick) begin
      next_phase     = ~phase;
      next_core_tick = phase;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase           <= 1'b0;
      core_clock_tick <= 1'b0;
    end else begin
      phase           <= next_phase;
      core_clock_tick <= next_core_tick;
    end
  end

  logic rx_prev;
  logic vco_prev;
  wire logic rx_edge  = rx_level ^ rx_prev;
  wire logic vco_edge = vco_level & ~vco_prev;

  logic [$clog2(MS_COUNT)-1:0] ms_div;
  logic [$clog2(MS_COUNT)-1:0] next_ms_div;
  wire logic ms_tick = (int'(ms_div) == MS_COUNT - 1);

  logic [10:0]   silent_ms;
  logic [10:0]   next_silent_ms;
  logic [10:0]   judge_ms;
  dcsrx_mon_type mon;
  dcsrx_mon_type next_mon;

  always_comb begin
    case (fs_select)
      FS_32K:  judge_ms = JUDGE_MS_32K;
      FS_44K1: judge_ms = JUDGE_MS_44K1;
      FS_48K:  judge_ms = JUDGE_MS_48K;
      FS_96K:  judge_ms = JUDGE_MS_96K;
      default: judge_ms = JUDGE_MS_32K;
    endcase
  end

  always_comb begin
    next_ms_div    = ms_tick ? '0 : ms_div + 1'b1;
    next_silent_ms = silent_ms;
    next_mon       = mon;
    if (rx_edge) begin
      next_ms_div    = '0;
      next_silent_ms = 11'h0;
    end else if (ms_tick && silent_ms < judge_ms) begin
      next_silent_ms = silent_ms + 11'h1;
    end
    case (mon)
      DCSRX_WAIT: if (rx_edge) next_mon = DCSRX_ACTV;
      DCSRX_ACTV: if (!rx_edge && silent_ms >= judge_ms)
                    next_mon = DCSRX_FREE;
      DCSRX_FREE: if (rx_edge) next_mon = DCSRX_ACTV;
      default:    next_mon = DCSRX_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev   <= 1'b0;
      vco_prev  <= 1'b0;
      ms_div    <= '0;
      silent_ms <= 11'h0;
      mon       <= DCSRX_WAIT;
    end else begin
      rx_prev   <= rx_level;
      vco_prev  <= vco_level;
      ms_div    <= next_ms_div;
      silent_ms <= next_silent_ms;
      mon       <= next_mon;
    end
  end

  // VCO edges are counted per receive edge interval; a count outside
  // the window means the loop sits on a wrong harmonic.
  logic [7:0] vco_cnt;
  logic [7:0] next_vco_cnt;
  logic       escape;
  logic       next_escape;

  always_comb begin
    next_vco_cnt = vco_cnt;
    next_escape  = escape;
    if (vco_edge && vco_cnt != 8'hff) begin
      next_vco_cnt = vco_cnt + 8'h1;
    end
    if (rx_edge) begin
      next_vco_cnt = 8'h0;
      next_escape  = (mon == DCSRX_ACTV) &&
                     (vco_cnt < 8'(VCO_MIN) || vco_cnt > 8'(VCO_MAX));
    end
    if (mon == DCSRX_FREE) begin
      next_escape = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vco_cnt <= 8'h0;
      escape  <= 1'b0;
    end else begin
      vco_cnt <= next_vco_cnt;
      escape  <= next_escape;
    end
  end

  logic        next_free;
  logic [16:0] next_khz;
  logic        next_lock;

  always_comb begin
    next_free = (next_mon == DCSRX_FREE);
    next_khz  = next_free ? FREE_RUN_KHZ : 17'h0;
    next_lock = pll_lock && (next_mon == DCSRX_ACTV) && !next_escape;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vco_free_run          <= 1'b0;
      recovered_clock_khz   <= 17'h0;
      clock_switch_request  <= 1'b0;
      false_lock_escape_out <= 1'b0;
      false_lock_escape_oe  <= 1'b0;
      lock_out              <= 1'b0;
      hold_received         <= 1'b1;
    end else begin
      vco_free_run          <= next_free;
      recovered_clock_khz   <= next_khz;
      clock_switch_request  <= next_free;
      false_lock_escape_out <= next_escape;
      false_lock_escape_oe  <= next_escape;
      lock_out              <= next_lock;
      hold_received         <= ~next_lock;
    end
  end

  sequence s_silent_full;
    mon == DCSRX_ACTV && !rx_edge && silent_ms >= judge_ms;
  endsequence
  sequence s_free_seen;
    vco_free_run && recovered_clock_khz == FREE_RUN_KHZ;
  endsequence
  a_free_after_judge: assert property (
    s_silent_full |=> s_free_seen)
    else $error("free run not entered after judgment time");
  a_free_freq: assert property (
    vco_free_run |-> recovered_clock_khz == FREE_RUN_KHZ)
    else $error("free run frequency wrong");
  a_switch_req: assert property (
    $rose(vco_free_run) |-> clock_switch_request)
    else $error("clock switch not requested on loss");
  a_edge_leaves_free: assert property (
    mon == DCSRX_FREE && rx_edge |=> !vco_free_run)
    else $error("receive edge did not end free run");
  a_escape_pin: assert property (
    escape |-> false_lock_escape_oe && false_lock_escape_out)
    else $error("escape not driven on false lock");
  a_escape_cause: assert property (
    $rose(escape) |-> $past(rx_edge) &&
      ($past(vco_cnt) < 8'(VCO_MIN) || $past(vco_cnt) > 8'(VCO_MAX)))
    else $error("escape without out-of-window interval");
  a_lock_hold: assert property (
    lock_out |-> !hold_received && !vco_free_run && !false_lock_escape_oe)
    else $error("lock output inconsistent");
  a_core_half: assert property (
    core_clock_tick |-> !next_core_tick ##1 !core_clock_tick)
    else $error("core tick faster than half rate");
  a_cfg_static: assert property (
    cfg_done |=> $stable(clock_cfg))
    else $error("clock config changed after capture");
  a_cfg_map: assert property (
    $rose(cfg_done) |-> clock_cfg.bypass == (clock_cfg.mult == MULT_NONE))
    else $error("bypass and multiplier disagree");

endmodule : dcsrx_top

//--- dv/dcsrx_partner.sv
`timescale 1ns/1ps
module dcsrx_partner (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Controls from the bench
  input  wire logic       rx_en,
  input  wire logic [7:0] rx_gap,
  input  wire logic       vco_run,
  input  wire logic       lock_lvl,
  // Pins toward the block
  output logic            dll_clock_tick,
  output logic            rx_in,
  output logic            vco_clock_in,
  output logic            pll_lock_in
);
  logic [1:0] tick_cnt;
  logic [1:0] vco_cnt;
  logic [7:0] rx_cnt;

  // A silent transmitter leaves the line at its last level, as a real one.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt       <= 2'h0;
      vco_cnt        <= 2'h0;
      rx_cnt         <= 8'h0;
      dll_clock_tick <= 1'b0;
      rx_in          <= 1'b0;
      vco_clock_in   <= 1'b0;
      pll_lock_in    <= 1'b0;
    end else begin
      // One tick every third cycle keeps the DLL rate well inside its limit.
      tick_cnt       <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
      dll_clock_tick <= (tick_cnt == 2'h2);
      vco_cnt        <= vco_cnt + 2'h1;
      if (vco_run && vco_cnt == 2'h3) begin
        vco_clock_in <= ~vco_clock_in;
      end
      // Every far-side pin is timed from the one shared master clock.
      rx_cnt <= (rx_cnt >= rx_gap) ? 8'h0 : rx_cnt + 8'h1;
      if (rx_en && rx_cnt >= rx_gap) begin
        rx_in <= ~rx_in;
      end
      pll_lock_in <= lock_lvl;
    end
  end
endmodule : dcsrx_partner

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dcsrx_pkg::*;
  localparam int MSC = 4;
  logic          ref_clk   = 1'b0;
  logic          arst_n    = 1'b0;
  logic          ratio_sel = 1'b0;
  logic          en_sel    = 1'b0;
  logic          rx_en     = 1'b0;
  logic          vco_run   = 1'b0;
  logic          lock_lvl  = 1'b0;
  logic [7:0]    rx_gap    = 8'h2f;
  logic [1:0]    fs_select = 2'h0;
  logic          dll_tick, rx_in, vco_in, pll_lock, core_tick, free_run;
  logic          sw_req, esc, esc_oe, lock_out, hold;
  logic [16:0]   khz;
  dcsrx_cfg_type cfg;
  int            err_total = 0;
  int            checks    = 0;
  int            seed      = 32'h80e3;
  int            n, dll_n, core_n;

  always #25 ref_clk = ~ref_clk;

  dcsrx_partner u_far (
    .ref_clk(ref_clk), .arst_n(arst_n), .rx_en(rx_en), .rx_gap(rx_gap),
    .vco_run(vco_run), .lock_lvl(lock_lvl), .dll_clock_tick(dll_tick),
    .rx_in(rx_in), .vco_clock_in(vco_in), .pll_lock_in(pll_lock)
  );

  dcsrx_top #(.MS_COUNT(MSC)) DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .dll_ratio_select(ratio_sel),
    .dll_enable_select(en_sel), .dll_clock_tick(dll_tick), .rx_in(rx_in),
    .vco_clock_in(vco_in), .pll_lock_in(pll_lock), .fs_select(fs_select),
    .clock_cfg(cfg), .core_clock_tick(core_tick), .vco_free_run(free_run),
    .recovered_clock_khz(khz), .clock_switch_request(sw_req),
    .false_lock_escape_out(esc), .false_lock_escape_oe(esc_oe),
    .lock_out(lock_out), .hold_received(hold)
  );

  function automatic dcsrx_cfg_type exp_cfg(input logic [1:0] s);
    case (s)
      SEL_BYPASS: return {1'b1, MULT_NONE};
      SEL_MUL4:   return {1'b0, MULT_X4};
      SEL_MUL3:   return {1'b0, MULT_X3};
      default:    return {1'b0, MULT_X6};
    endcase
  endfunction : exp_cfg

  function automatic int judge(input logic [1:0] f);
    case (f)
      2'h0:    return 1000 * MSC;
      2'h1:    return 750 * MSC;
      2'h2:    return 700 * MSC;
      default: return 350 * MSC;
    endcase
  endfunction : judge

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      arst_n = 1'b0;
      {ratio_sel, en_sel} = s;
      cyc(10);
      chk(cfg === {1'b1, MULT_NONE}, "reset config");
      chk(hold === 1'b1 && lock_out === 1'b0, "reset outputs");
      arst_n = 1'b1;
      cyc(10);
      chk(cfg === exp_cfg(s), "clock select");
      {ratio_sel, en_sel} = ~s;
      cyc(10);
      chk(cfg === exp_cfg(s), "late pin change taken");
    end
    $display("test clock select done");
    dll_n = 0;
    core_n = 0;
    repeat (600) begin
      cyc(1);
      dll_n += int'(dll_tick);
      core_n += int'(core_tick);
    end
    n = core_n * 2 - dll_n;
    chk(core_n > 90, "core ticks seen");
    chk(n >= -2 && n <= 2, "core rate");
    $display("test core divide done");
    rx_en = 1'b1;
    vco_run = 1'b1;
    lock_lvl = 1'b1;
    repeat (3) begin
      rx_gap = 8'(8 * (4 + ($unsigned($random(seed)) % 6)) - 1);
      cyc(400);
      chk(lock_out === 1'b1 && hold === 1'b0, "lock");
      chk(esc === 1'b0, "escape while locked");
      lock_lvl = 1'b0;
      cyc(10);
      chk(lock_out === 1'b0 && hold === 1'b1, "unlock");
      lock_lvl = 1'b1;
    end
    $display("test lock done");
    // Stopped VCO, in-window, receive gap far too long for the VCO, in-window again.
    for (int i = 0; i < 4; i++) begin
      vco_run = (i != 0);
      rx_gap = (i == 2) ? 8'h9f : 8'h2f;
      cyc(700);
      chk(esc === !i[0] && esc_oe === !i[0], "false lock");
      chk(lock_out === i[0], "lock under escape");
    end
    $display("test false lock done");
    for (int i = 0; i < 4; i++) begin
      fs_select = 2'(3 - i);
      rx_en = 1'b1;
      cyc(100);
      rx_en = 1'b0;
      n = 0;
      while (free_run !== 1'b1) begin
        if (n > judge(fs_select) + 20) begin
          chk(1'b0, "free run timeout");
          summarize();
        end
        cyc(1);
        n++;
      end
      chk(n >= judge(fs_select) - 60, "free run early");
      chk(khz === 17'h13880, "free run rate");
      chk(sw_req === 1'b1, "free run switch");
      chk(lock_out === 1'b0, "free run lock");
      rx_en = 1'b1;
      // The far side may wait a whole gap before its next edge.
      cyc(60);
      chk(free_run === 1'b0 && khz === 17'h0, "input back");
      chk(sw_req === 1'b0, "switch withdrawn");
    end
    $display("test no input done");
    summarize();
  end
endmodule : tb_top
